// file: src/sre_params.svh
`ifndef SRE_PARAMS_SVH
`define SRE_PARAMS_SVH

// Opcode match patterns, compared against the top bits of the word
`define SRE_OPC_BRANCH_HS   8'h86
`define SRE_OPC_CALL        7'h04
`define SRE_OPC_RET         13'h0010
`define SRE_OPC_MARK        10'h034

// Field positions
`define SRE_BR_OFF_MSB      7
`define SRE_LINK_MSB        8
`define SRE_LINK_LSB        6
`define SRE_RET_REG_MSB     2
`define SRE_PCOUNT_MSB      5

// Register indices
`define SRE_IDX_FRAME       3'h5
`define SRE_IDX_STACK       3'h6
`define SRE_IDX_PROG        3'h7

// Stack step and reset values
`define SRE_WORD_STEP       16'h0002
`define SRE_PROG_RESET      16'h0000
`define SRE_STACK_RESET     16'h0000
`define SRE_GPR_RESET       16'h0000

`endif

// file: src/sre_pkg.sv
package sre_pkg;

  typedef enum logic [1:0] {
    SRE_S_IDLE = 2'b00,
    SRE_S_RD   = 2'b01,
    SRE_S_PUSH = 2'b10,
    SRE_S_POP  = 2'b11
  } sre_state_t;

  typedef enum logic [1:0] {
    SRE_OP_NONE = 2'b00,
    SRE_OP_CALL = 2'b01,
    SRE_OP_RET  = 2'b10,
    SRE_OP_MARK = 2'b11
  } sre_op_t;

endpackage

// file: src/sre_regfile.sv
`timescale 1ns/1ps
`include "sre_params.svh"

module sre_regfile #(
  parameter int W     = 16,
  parameter int DEPTH = 6
) (
  input  wire logic         clock,
  input  wire logic         srst,
  input  wire logic         ce,
  input  wire logic         we,
  input  wire logic [2:0]   waddr,
  input  wire logic [W-1:0] wdata,
  input  wire logic [2:0]   raddr,
  output logic      [W-1:0] rdata,
  input  wire logic [2:0]   peek_addr,
  output logic      [W-1:0] peek_data
);

  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] mem_d [DEPTH];
  logic [W-1:0] rdata_d;
  logic [W-1:0] peek_d;

  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      mem_d[i] = mem_q[i];
    end
    if (we && (int'(waddr) < DEPTH))
    begin
      mem_d[waddr] = wdata;
    end
    // Out-of-range reads return zero
    rdata_d = (int'(raddr) < DEPTH) ? mem_q[raddr] : '0;
    peek_d  = (int'(peek_addr) < DEPTH) ? mem_q[peek_addr] : '0;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_q[i] <= `SRE_GPR_RESET;
      end
      rdata     <= '0;
      peek_data <= '0;
    end
    else if (ce)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_q[i] <= mem_d[i];
      end
      rdata     <= rdata_d;
      peek_data <= peek_d;
    end
  end

endmodule // sre_regfile

// file: src/sre_exec.sv
`timescale 1ns/1ps
`include "sre_params.svh"

// Operation
// - Higher-or-same branch adds twice offset to counter only when carry clear
// - Call opcode 004 holds link register 8:6; destination latched into temp
// - Call pushes old link value, link gets return address, counter gets temp
// - Counter takes the destination effective address, not the word there
// - Call linking through the counter changes only stack pointer and counter
// - Call via counter, autoincrement-deferred stack destination swaps stack top
// - Return 00020: counter takes register, then stack top pops into register
// - Mark sets stack pointer to counter plus twice six-bit parameter count
// - Mark then copies frame link register to counter and pops into it
module sre_exec #(
  parameter int W = 16
) (
  input  wire logic         clock,
  input  wire logic         srst,
  input  wire logic         ce,
  input  wire logic [W-1:0] instr,
  input  wire logic         instr_valid,
  output logic              instr_ready,
  input  wire logic [W-1:0] dest_ea,
  input  wire logic         dest_sp_incr,
  input  wire logic         cond_carry,
  output logic              mem_req,
  output logic              mem_we,
  output logic      [W-1:0] mem_addr,
  output logic      [W-1:0] mem_wdata,
  input  wire logic [W-1:0] mem_rdata,
  input  wire logic         mem_ack,
  input  wire logic         ld_en,
  input  wire logic [2:0]   ld_addr,
  input  wire logic [W-1:0] ld_data,
  input  wire logic [2:0]   peek_addr,
  output logic      [W-1:0] peek_data,
  output logic      [W-1:0] program_counter,
  output logic      [W-1:0] stack_pointer,
  output logic              done,
  output logic              illegal
);

  sre_pkg::sre_state_t state_q, state_d;
  sre_pkg::sre_op_t    op_q, op_d;
  logic [2:0]          reg_q, reg_d;
  logic [W-1:0]        tmp_q, tmp_d;
  logic [W-1:0]        link_q, link_d;
  logic [W-1:0]        prog_ctr_q, prog_ctr_d;
  logic [W-1:0]        stk_ptr_q, stk_ptr_d;
  logic                done_q, done_d;
  logic                illegal_q, illegal_d;
  logic                rf_we;
  logic [2:0]          rf_waddr;
  logic [W-1:0]        rf_wdata;
  logic [2:0]          rf_raddr;
  logic [W-1:0]        rf_rdata;
  logic [W-1:0]        rd_val;
  logic [W-1:0]        br_off;
  logic [W-1:0]        parm_off;
  logic                is_branch_hs;
  logic                is_call;
  logic                is_ret;
  logic                is_mark;

  assign is_branch_hs = instr[W-1:8] == `SRE_OPC_BRANCH_HS;
  assign is_call      = instr[W-1:9] == `SRE_OPC_CALL;
  assign is_ret       = instr[W-1:3] == `SRE_OPC_RET;
  assign is_mark      = instr[W-1:6] == `SRE_OPC_MARK;
  // Signed word offset, doubled
  assign br_off   = {{(W-9){instr[`SRE_BR_OFF_MSB]}}, instr[`SRE_BR_OFF_MSB:0], 1'b0};
  assign parm_off = {{(W-7){1'b0}}, instr[`SRE_PCOUNT_MSB:0], 1'b0};
  // Counter and stack pointer live here, not in the file
  assign rd_val = (reg_q == `SRE_IDX_PROG)  ? prog_ctr_q :
                  (reg_q == `SRE_IDX_STACK) ? stk_ptr_q  : rf_rdata;

  assign instr_ready     = state_q == sre_pkg::SRE_S_IDLE;
  assign mem_req         = (state_q == sre_pkg::SRE_S_PUSH) || (state_q == sre_pkg::SRE_S_POP);
  assign mem_we          = state_q == sre_pkg::SRE_S_PUSH;
  assign mem_addr        = stk_ptr_q;
  assign mem_wdata       = link_q;
  assign program_counter = prog_ctr_q;
  assign stack_pointer   = stk_ptr_q;
  assign done            = done_q;
  assign illegal         = illegal_q;

  always_comb
  begin
    state_d    = state_q;
    op_d       = op_q;
    reg_d      = reg_q;
    tmp_d      = tmp_q;
    link_d     = link_q;
    prog_ctr_d = prog_ctr_q;
    stk_ptr_d  = stk_ptr_q;
    done_d     = 1'b0;
    illegal_d  = 1'b0;
    rf_we      = 1'b0;
    rf_waddr   = ld_addr;
    rf_wdata   = ld_data;
    // Read issued on the accept edge, consumed in the read state
    rf_raddr   = is_mark ? `SRE_IDX_FRAME :
                 is_call ? instr[`SRE_LINK_MSB:`SRE_LINK_LSB] : instr[`SRE_RET_REG_MSB:0];
    case (state_q)
      sre_pkg::SRE_S_IDLE:
      begin
        if (instr_valid)
        begin
          if (is_branch_hs)
          begin
            if (!cond_carry)
            begin
              prog_ctr_d = prog_ctr_q + br_off;
            end
            done_d = 1'b1;
          end
          else if (is_call)
          begin
            op_d  = sre_pkg::SRE_OP_CALL;
            reg_d = instr[`SRE_LINK_MSB:`SRE_LINK_LSB];
            tmp_d = dest_ea;
            if (dest_sp_incr)
            begin
              stk_ptr_d = stk_ptr_q + `SRE_WORD_STEP;
            end
            state_d = sre_pkg::SRE_S_RD;
          end
          else if (is_ret)
          begin
            op_d    = sre_pkg::SRE_OP_RET;
            reg_d   = instr[`SRE_RET_REG_MSB:0];
            state_d = sre_pkg::SRE_S_RD;
          end
          else if (is_mark)
          begin
            op_d      = sre_pkg::SRE_OP_MARK;
            reg_d     = `SRE_IDX_FRAME;
            stk_ptr_d = prog_ctr_q + parm_off;
            state_d   = sre_pkg::SRE_S_RD;
          end
          else
          begin
            illegal_d = 1'b1;
          end
        end
        else if (ld_en)
        begin
          if (ld_addr == `SRE_IDX_PROG)
          begin
            prog_ctr_d = ld_data;
          end
          else if (ld_addr == `SRE_IDX_STACK)
          begin
            stk_ptr_d = ld_data;
          end
          else
          begin
            rf_we = 1'b1;
          end
        end
      end
      sre_pkg::SRE_S_RD:
      begin
        if (op_q == sre_pkg::SRE_OP_CALL)
        begin
          link_d    = rd_val;
          stk_ptr_d = stk_ptr_q - `SRE_WORD_STEP;
          state_d   = sre_pkg::SRE_S_PUSH;
        end
        else
        begin
          prog_ctr_d = rd_val;
          state_d    = sre_pkg::SRE_S_POP;
        end
      end
      sre_pkg::SRE_S_PUSH:
      begin
        if (mem_ack)
        begin
          // Linking through the counter writes nothing else
          if (reg_q == `SRE_IDX_STACK)
          begin
            stk_ptr_d = prog_ctr_q;
          end
          else if (reg_q != `SRE_IDX_PROG)
          begin
            rf_we    = 1'b1;
            rf_waddr = reg_q;
            rf_wdata = prog_ctr_q;
          end
          prog_ctr_d = tmp_q;
          done_d     = 1'b1;
          state_d    = sre_pkg::SRE_S_IDLE;
        end
      end
      sre_pkg::SRE_S_POP:
      begin
        if (mem_ack)
        begin
          stk_ptr_d = stk_ptr_q + `SRE_WORD_STEP;
          // Popped word wins over the increment when the target is the stack pointer
          if (reg_q == `SRE_IDX_PROG)
          begin
            prog_ctr_d = mem_rdata;
          end
          else if (reg_q == `SRE_IDX_STACK)
          begin
            stk_ptr_d = mem_rdata;
          end
          else
          begin
            rf_we    = 1'b1;
            rf_waddr = reg_q;
            rf_wdata = mem_rdata;
          end
          done_d  = 1'b1;
          state_d = sre_pkg::SRE_S_IDLE;
        end
      end
      default:
      begin
        state_d = sre_pkg::SRE_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_q    <= sre_pkg::SRE_S_IDLE;
      op_q       <= sre_pkg::SRE_OP_NONE;
      reg_q      <= 3'h0;
      tmp_q      <= '0;
      link_q     <= '0;
      prog_ctr_q <= `SRE_PROG_RESET;
      stk_ptr_q  <= `SRE_STACK_RESET;
      done_q     <= 1'b0;
      illegal_q  <= 1'b0;
    end
    else if (ce)
    begin
      state_q    <= state_d;
      op_q       <= op_d;
      reg_q      <= reg_d;
      tmp_q      <= tmp_d;
      link_q     <= link_d;
      prog_ctr_q <= prog_ctr_d;
      stk_ptr_q  <= stk_ptr_d;
      done_q     <= done_d;
      illegal_q  <= illegal_d;
    end
  end

  sre_regfile #(
    .W     (W),
    .DEPTH (6)
  ) u_regfile (
    .clock     (clock),
    .srst      (srst),
    .ce        (ce),
    .we        (rf_we),
    .waddr     (rf_waddr),
    .wdata     (rf_wdata),
    .raddr     (rf_raddr),
    .rdata     (rf_rdata),
    .peek_addr (peek_addr),
    .peek_data (peek_data)
  );

  // Checks are skipped while the clock enable holds state
  property p_branch_taken;
    @(posedge clock) disable iff (srst || !ce)
    (instr_ready && instr_valid && is_branch_hs && !cond_carry)
      |=> prog_ctr_q == $past(prog_ctr_q) + $past(br_off);
  endproperty
  a_branch_taken: assert property (p_branch_taken) else $error("branch not taken");

  property p_branch_held;
    @(posedge clock) disable iff (srst || !ce)
    (instr_ready && instr_valid && is_branch_hs && cond_carry) |=> $stable(prog_ctr_q) && done_q;
  endproperty
  a_branch_held: assert property (p_branch_held) else $error("branch taken on carry");

  property p_call_latch;
    @(posedge clock) disable iff (srst || !ce)
    (instr_ready && instr_valid && is_call)
      |=> tmp_q == $past(dest_ea) && state_q == sre_pkg::SRE_S_RD;
  endproperty
  a_call_latch: assert property (p_call_latch) else $error("call target not latched");

  property p_call_jump;
    @(posedge clock) disable iff (srst || !ce)
    (state_q == sre_pkg::SRE_S_PUSH && mem_ack)
      |=> prog_ctr_q == $past(tmp_q) && instr_ready && done_q;
  endproperty
  a_call_jump: assert property (p_call_jump) else $error("counter not loaded");

  property p_call_quiet;
    @(posedge clock) disable iff (srst || !ce)
    (!instr_ready && op_q == sre_pkg::SRE_OP_CALL && reg_q == `SRE_IDX_PROG) |-> !rf_we;
  endproperty
  a_call_quiet: assert property (p_call_quiet) else $error("general register touched");

  property p_swap_incr;
    @(posedge clock) disable iff (srst || !ce)
    (instr_ready && instr_valid && is_call && dest_sp_incr)
      |=> stk_ptr_q == $past(stk_ptr_q) + `SRE_WORD_STEP ##1 stk_ptr_q == $past(stk_ptr_q, 2);
  endproperty
  a_swap_incr: assert property (p_swap_incr) else $error("stack swap misaligned");

  property p_ret_first;
    @(posedge clock) disable iff (srst || !ce)
    (state_q == sre_pkg::SRE_S_RD && op_q != sre_pkg::SRE_OP_CALL)
      |=> prog_ctr_q == $past(rd_val) && mem_req && !mem_we;
  endproperty
  a_ret_first: assert property (p_ret_first) else $error("return counter wrong");

  property p_mark_adjust;
    @(posedge clock) disable iff (srst || !ce)
    (instr_ready && instr_valid && is_mark) |=> stk_ptr_q == $past(prog_ctr_q) + $past(parm_off);
  endproperty
  a_mark_adjust: assert property (p_mark_adjust) else $error("mark stack adjust wrong");

  property p_mark_pop;
    @(posedge clock) disable iff (srst || !ce)
    (state_q == sre_pkg::SRE_S_POP && mem_ack && op_q == sre_pkg::SRE_OP_MARK)
      |-> rf_we && rf_waddr == `SRE_IDX_FRAME && rf_wdata == mem_rdata;
  endproperty
  a_mark_pop: assert property (p_mark_pop) else $error("frame register not popped");

  property p_push_dec;
    @(posedge clock) disable iff (srst || !ce)
    (state_q == sre_pkg::SRE_S_RD && op_q == sre_pkg::SRE_OP_CALL)
      |=> mem_we && mem_addr == $past(stk_ptr_q) - `SRE_WORD_STEP;
  endproperty
  a_push_dec: assert property (p_push_dec) else $error("push not predecremented");

endmodule // sre_exec

// file: sim/sre_mem_model.sv
`timescale 1ns/1ps

module sre_mem_model (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [1:0]  lat,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic      [15:0] mem_rdata,
  output logic             mem_ack
);
  // One space for code and data, so the stack is always mapped
  logic [15:0] mem [0:32767];
  logic [1:0]  wait_cnt;

  always @(posedge clock)
  begin
    mem_ack <= 1'b0;
    if (srst)
    begin
      wait_cnt  <= 2'h0;
      mem_rdata <= 16'h5a5a;
    end
    else if (mem_req && !mem_ack && wait_cnt >= lat)
    begin
      mem_ack  <= 1'b1;
      wait_cnt <= 2'h0;
      if (mem_we)
        mem[mem_addr[15:1]] <= mem_wdata;
      else
        mem_rdata <= mem[mem_addr[15:1]];
    end
    else
    begin
      // Stale read data would hide a late sample
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack)
        wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule // sre_mem_model

// file: sim/test_subroutine_call_return_exec.sv
`timescale 1ns/1ps

module test_subroutine_call_return_exec;
  logic        clock, srst, ce, instr_valid, instr_ready, dest_sp_incr, cond_carry;
  logic        mem_req, mem_we, mem_ack, ld_en, done, illegal;
  logic [15:0] instr, dest_ea, mem_addr, mem_wdata, mem_rdata, ld_data, peek_data;
  logic [15:0] program_counter, stack_pointer, pc, sp, tmp, ret, w, rnd_state;
  logic [15:0] rf [0:5];
  logic [2:0]  ld_addr, peek_addr;
  logic [1:0]  lat;
  logic [7:0]  off;
  logic [5:0]  nn;
  logic [32:0] expect_q [$];
  int          mismatches, checked, i;

  sre_exec DUT (.clock(clock), .srst(srst), .ce(ce), .instr(instr),
    .instr_valid(instr_valid), .instr_ready(instr_ready), .dest_ea(dest_ea),
    .dest_sp_incr(dest_sp_incr), .cond_carry(cond_carry), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .ld_en(ld_en), .ld_addr(ld_addr), .ld_data(ld_data),
    .peek_addr(peek_addr), .peek_data(peek_data), .program_counter(program_counter),
    .stack_pointer(stack_pointer), .done(done), .illegal(illegal));

  sre_mem_model mem_i (.clock(clock), .srst(srst), .lat(lat), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  function automatic logic [15:0] rnd();
    rnd_state = rnd_state ^ (rnd_state << 7);
    rnd_state = rnd_state ^ (rnd_state >> 9);
    rnd_state = rnd_state ^ (rnd_state << 8);
    return rnd_state;
  endfunction

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic load(input logic [2:0] a, input logic [15:0] d);
    @(posedge clock);
    #1;
    ld_en   = 1'b1;
    ld_addr = a;
    ld_data = d;
    @(posedge clock);
    #1;
    ld_en = 1'b0;
  endtask

  // Caller sets pc and sp to the values expected at completion
  task automatic run(input logic [15:0] op, input logic [15:0] dst, input logic inc,
                     input logic ill);
    int n;
    expect_q.push_back({ill, pc, sp});
    @(posedge clock);
    #1;
    instr        = op;
    dest_ea      = dst;
    dest_sp_incr = inc;
    instr_valid  = 1'b1;
    tmp          = rnd();
    lat          = tmp[1:0];
    @(posedge clock);
    #1;
    instr_valid = 1'b0;
    for (n = 0; n < 40; n++)
    begin
      if (done === 1'b1 || illegal === 1'b1)
        break;
      @(posedge clock);
      #1;
    end
    if (n == 40)
      check(33'h0, 33'h1);
  endtask

  task automatic chk_reg(input logic [2:0] a, input logic [15:0] exp);
    @(posedge clock);
    #1;
    peek_addr = a;
    @(posedge clock);
    @(posedge clock);
    #1;
    check({17'h0, peek_data}, {17'h0, exp});
  endtask

  // Result watcher takes the oldest note on each completion pulse
  always @(posedge clock)
  begin
    if (done === 1'b1 || illegal === 1'b1)
    begin
      if (expect_q.size() == 0)
        check(33'h1, 33'h0);
      else
        check({illegal, program_counter, stack_pointer}, expect_q.pop_front());
    end
  end

  initial
  begin
    #40000;
    mismatches++;
    end_of_test();
  end

  initial
  begin
    {ce, srst} = 2'b11;
    {instr_valid, dest_sp_incr, cond_carry, ld_en} = 4'h0;
    {instr, dest_ea, ld_data} = 48'h0;
    {ld_addr, peek_addr, lat} = 8'h0;
    rnd_state = 16'h939a;
    mismatches = 0;
    checked = 0;
    repeat (20) @(posedge clock);
    #1;
    srst = 1'b0;
    for (i = 0; i < 6; i++)
    begin
      rf[i] = rnd();
      load(i[2:0], rf[i]);
    end
    sp = 16'h0400;
    load(3'h6, sp);
    pc = 16'h1000;
    load(3'h7, pc);
    // Offset extremes first, then random offsets and carry
    for (i = 0; i < 10; i++)
    begin
      tmp        = rnd();
      off        = (i == 0) ? 8'h80 : (i == 1) ? 8'h7f : tmp[7:0];
      cond_carry = (i < 2) ? 1'b0 : tmp[8];
      if (!cond_carry)
        pc = pc + {{7{off[7]}}, off, 1'b0};
      run({8'h86, off}, 16'h0, 1'b0, 1'b0);
    end
    run(16'h8700, 16'h0, 1'b0, 1'b1);
    // Call through r1 to location 0x40, then return
    ret = pc;
    w   = rf[1];
    pc  = 16'h0040;
    sp  = sp - 16'h0002;
    run({7'h04, 3'h1, 6'h09}, 16'h0040, 1'b0, 1'b0);
    check({17'h0, mem_i.mem[sp[15:1]]}, {17'h0, w});
    chk_reg(3'h1, ret);
    pc = ret;
    sp = sp + 16'h0002;
    run(16'h0081, 16'h0, 1'b0, 1'b0);
    chk_reg(3'h1, w);
    // Co-routine swap with the stack top
    tmp = rnd() & 16'hfffe;
    mem_i.mem[sp[15:1]] = tmp;
    ret = pc;
    pc  = tmp;
    run(16'h09de, tmp, 1'b1, 1'b0);
    check({17'h0, mem_i.mem[sp[15:1]]}, {17'h0, ret});
    for (i = 0; i < 6; i++)
      chk_reg(i[2:0], rf[i]);
    pc = ret;
    sp = sp + 16'h0002;
    run(16'h0087, 16'h0, 1'b0, 1'b0);
    // Enable low must hold the stack pointer against a load; one edge first clears done
    @(posedge clock);
    #1;
    ce = 1'b0;
    load(3'h6, ~sp);
    check({17'h0, stack_pointer}, {17'h0, sp});
    ce = 1'b1;
    // Largest count first, then a random one
    for (i = 0; i < 2; i++)
    begin
      tmp = rnd();
      nn  = (i == 0) ? 6'h3f : tmp[5:0];
      w   = rnd();
      sp  = pc + {9'h0, nn, 1'b0};
      mem_i.mem[sp[15:1]] = w;
      sp    = sp + 16'h0002;
      pc    = rf[5];
      rf[5] = w;
      run({10'h034, nn}, 16'h0, 1'b0, 1'b0);
      chk_reg(3'h5, w);
    end
    repeat (5) @(posedge clock);
    end_of_test();
  end
endmodule // test_subroutine_call_return_exec
